// >>> logic/spic_pkg.sv
// Constants and types shared by the serial port interrupt control block
package spic_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_EN_A = 8'h04;
    localparam logic [7:0] OFF_FLAG_A = 8'h08;
    localparam logic [7:0] OFF_PRIO_A = 8'h0c;
    localparam logic [7:0] OFF_EN_B = 8'h10;
    localparam logic [7:0] OFF_FLAG_B = 8'h14;
    localparam logic [7:0] OFF_PRIO_B = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFF_CORE_STAT = 8'h24;
    // Control register fields
    localparam int CTRL_VARIANT = 0;
    localparam int CTRL_PRIO_MODE = 1;
    localparam int CTRL_GLOBAL_DIS = 2;
    localparam int CTRL_PERIPH_EN = 3;
    localparam int CTRL_GLOBAL_EN = 4;
    localparam logic [4:0] CTRL_RESET = 5'h04;
    // Source fields within a port register
    localparam int SRC_TX = 0;
    localparam int SRC_RX = 1;
    // Vector addresses
    localparam logic [15:0] VEC_PERIPH = 16'h0020;
    localparam logic [15:0] VEC_HIGH = 16'h0008;
    localparam logic [15:0] VEC_LOW = 16'h0018;
    // Bus codes
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // Kind of the request offered to the core
    typedef enum logic [1:0] {
        KIND_SINGLE,
        KIND_UNPRIO,
        KIND_HIGH,
        KIND_LOW
    } spic_kind_t;
endpackage

// >>> logic/spic_top.sv
// Serial port interrupt control with AHB-Lite register access
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - A set flag with its enable and global enables raises an interrupt.
// - Single-level: request only with global disable clear and peripheral enable set.
// - Single-level: taking an interrupt sets the global disable bit.
// - Single-level: return clears the global disable bit.
// - Flags are set by serial hardware regardless of enables.
// - Flags come straight from serial hardware; no software clear needed.
// - Priority variant: one vector unprioritised, else high and low vectors.
// - Priority variant: taking saves working, status and bank select registers.
// - Priority mode off: global and peripheral enable both needed.
// - Priority mode on: source needs the global enable of its level.
// - Priority mode: high global enable clear blocks every interrupt.
// - Transmit and receive have separate enable bits.
// - Per-source priority bits, effective only in priority mode.
// - Second port has its own flag, enable and priority registers.
// - Single-level: serial interrupts vector to the peripheral vector.
module spic_top
    import spic_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Serial hardware flags, index 0 first port, 1 second port
    input wire logic [1:0] tx_int_flag,
    input wire logic [1:0] rx_int_flag,
    // Core sequencer
    output logic int_req,
    output logic [15:0] int_vector,
    input wire logic int_take,
    input wire logic int_return,
    // Core context
    input wire logic [7:0] working_register,
    input wire logic [7:0] alu_status_register,
    input wire logic [7:0] bank_select_register,
    output logic [7:0] saved_working,
    output logic [7:0] saved_status,
    output logic [7:0] saved_bank,
    // Event interrupt
    output logic irq
);

    // ************************************************
    // Bus slave
    // ************************************************
    logic wr_pend_q;
    logic [7:0] addr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_d;
    logic acc;

    assign acc = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend_q <= acc && hwrite;
            if (acc) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // Write strobes
    logic wr_ctrl, wr_irq_stat, wr_irq_mask;
    logic [1:0] wr_en, wr_prio;
    assign wr_ctrl = wr_pend_q && (addr_q == OFF_CTRL);
    assign wr_irq_stat = wr_pend_q && (addr_q == OFF_IRQ_STAT);
    assign wr_irq_mask = wr_pend_q && (addr_q == OFF_IRQ_MASK);
    assign wr_en = {wr_pend_q && (addr_q == OFF_EN_B), wr_pend_q && (addr_q == OFF_EN_A)};
    assign wr_prio = {wr_pend_q && (addr_q == OFF_PRIO_B), wr_pend_q && (addr_q == OFF_PRIO_A)};

    // ************************************************
    // Control and per-port registers
    // ************************************************
    logic variant_q;
    logic priority_mode_select_q;
    logic global_int_disable_q;
    logic peripheral_int_enable_q;
    logic global_int_enable_q;
    logic high_act_q, low_act_q;
    logic [1:0] tx_int_enable_q, rx_int_enable_q;
    logic [1:0] tx_int_priority_q, rx_int_priority_q;
    logic high_prio_global_enable, low_prio_global_enable;

    // Shared bits renamed for priority mode
    assign high_prio_global_enable = global_int_enable_q;
    assign low_prio_global_enable = peripheral_int_enable_q;

    // Separate enable and priority sets per port
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_int_enable_q <= 2'h0;
            rx_int_enable_q <= 2'h0;
            tx_int_priority_q <= 2'h3;
            rx_int_priority_q <= 2'h3;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (wr_en[p]) begin
                    tx_int_enable_q[p] <= hwdata[SRC_TX];
                    rx_int_enable_q[p] <= hwdata[SRC_RX];
                end
                if (wr_prio[p]) begin
                    tx_int_priority_q[p] <= hwdata[SRC_TX];
                    rx_int_priority_q[p] <= hwdata[SRC_RX];
                end
            end
        end
    end

    // ************************************************
    // Request evaluation
    // ************************************************
    logic [3:0] flags, enables, prios, pend;
    logic any_pend, hi_pend, lo_pend;
    logic req_d;
    logic [15:0] vec_d;
    spic_kind_t kind_d, kind_q;
    logic int_req_q;
    logic [15:0] int_vector_q;

    // Flags taken directly from the serial hardware
    assign flags = {rx_int_flag[1], tx_int_flag[1], rx_int_flag[0], tx_int_flag[0]};
    assign enables = {rx_int_enable_q[1], tx_int_enable_q[1], rx_int_enable_q[0], tx_int_enable_q[0]};
    assign prios = {rx_int_priority_q[1], tx_int_priority_q[1], rx_int_priority_q[0], tx_int_priority_q[0]};
    assign pend = flags & enables;
    assign any_pend = |pend;
    assign hi_pend = |(pend & prios);
    assign lo_pend = |(pend & ~prios);

    // Gating and vector selection
    always_comb begin
        req_d = 1'b0;
        kind_d = KIND_SINGLE;
        vec_d = VEC_PERIPH;
        if (!variant_q) begin
            req_d = !global_int_disable_q && peripheral_int_enable_q && any_pend;
        end else if (!priority_mode_select_q) begin
            req_d = global_int_enable_q && peripheral_int_enable_q && any_pend;
            kind_d = KIND_UNPRIO;
            vec_d = VEC_HIGH;
        end else if (high_prio_global_enable && hi_pend) begin
            req_d = 1'b1;
            kind_d = KIND_HIGH;
            vec_d = VEC_HIGH;
        end else if (high_prio_global_enable && low_prio_global_enable && lo_pend) begin
            req_d = 1'b1;
            kind_d = KIND_LOW;
            vec_d = VEC_LOW;
        end
    end

    // Registered request towards the core
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_req_q <= 1'b0;
            int_vector_q <= VEC_PERIPH;
            kind_q <= KIND_SINGLE;
        end else begin
            int_req_q <= req_d;
            int_vector_q <= vec_d;
            kind_q <= kind_d;
        end
    end
    assign int_req = int_req_q;
    assign int_vector = int_vector_q;

    // Control bits; core take and return override a bus write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            variant_q <= CTRL_RESET[CTRL_VARIANT];
            priority_mode_select_q <= CTRL_RESET[CTRL_PRIO_MODE];
            global_int_disable_q <= CTRL_RESET[CTRL_GLOBAL_DIS];
            peripheral_int_enable_q <= CTRL_RESET[CTRL_PERIPH_EN];
            global_int_enable_q <= CTRL_RESET[CTRL_GLOBAL_EN];
            high_act_q <= 1'b0;
            low_act_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                variant_q <= hwdata[CTRL_VARIANT];
                priority_mode_select_q <= hwdata[CTRL_PRIO_MODE];
                global_int_disable_q <= hwdata[CTRL_GLOBAL_DIS];
                peripheral_int_enable_q <= hwdata[CTRL_PERIPH_EN];
                global_int_enable_q <= hwdata[CTRL_GLOBAL_EN];
            end
            if (int_take && int_req_q) begin
                case (kind_q)
                    KIND_SINGLE: begin
                        global_int_disable_q <= 1'b1;
                    end
                    KIND_UNPRIO, KIND_HIGH: begin
                        global_int_enable_q <= 1'b0;
                        high_act_q <= 1'b1;
                    end
                    KIND_LOW: begin
                        peripheral_int_enable_q <= 1'b0;
                        low_act_q <= 1'b1;
                    end
                    default: begin
                        global_int_disable_q <= 1'b1;
                    end
                endcase
            end else if (int_return) begin
                if (!variant_q) begin
                    global_int_disable_q <= 1'b0;
                end else if (high_act_q) begin
                    global_int_enable_q <= 1'b1;
                    high_act_q <= 1'b0;
                end else if (low_act_q) begin
                    peripheral_int_enable_q <= 1'b1;
                    low_act_q <= 1'b0;
                end else begin
                    global_int_enable_q <= 1'b1;
                end
            end
        end
    end

    // ************************************************
    // Context save
    // ************************************************
    logic [7:0] saved_working_q, saved_status_q, saved_bank_q;

    // Snapshot on every take in the priority variant
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            saved_working_q <= 8'h00;
            saved_status_q <= 8'h00;
            saved_bank_q <= 8'h00;
        end else if (int_take && int_req_q && variant_q) begin
            saved_working_q <= working_register;
            saved_status_q <= alu_status_register;
            saved_bank_q <= bank_select_register;
        end
    end
    assign saved_working = saved_working_q;
    assign saved_status = saved_status_q;
    assign saved_bank = saved_bank_q;

    // ************************************************
    // Event status and mask
    // ************************************************
    logic [3:0] flag_prev_q, irq_stat_q, irq_mask_q, rise;
    logic irq_q;

    assign rise = flags & ~flag_prev_q;

    // Sticky flag rises, set wins over write-one-clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_prev_q <= 4'h0;
            irq_stat_q <= 4'h0;
            irq_mask_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            flag_prev_q <= flags;
            irq_stat_q <= (irq_stat_q & ~(wr_irq_stat ? hwdata[3:0] : 4'h0)) | rise;
            if (wr_irq_mask) begin
                irq_mask_q <= hwdata[3:0];
            end
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end
    assign irq = irq_q;

    // ************************************************
    // Read path
    // ************************************************
    always_comb begin
        rd_d = 32'h0000_0000;
        if (haddr[7:0] == OFF_CTRL) begin
            rd_d[4:0] = {global_int_enable_q, peripheral_int_enable_q, global_int_disable_q,
                         priority_mode_select_q, variant_q};
        end else if (haddr[7:0] == OFF_EN_A) begin
            rd_d[1:0] = {rx_int_enable_q[0], tx_int_enable_q[0]};
        end else if (haddr[7:0] == OFF_FLAG_A) begin
            rd_d[1:0] = {rx_int_flag[0], tx_int_flag[0]};
        end else if (haddr[7:0] == OFF_PRIO_A) begin
            rd_d[1:0] = {rx_int_priority_q[0], tx_int_priority_q[0]};
        end else if (haddr[7:0] == OFF_EN_B) begin
            rd_d[1:0] = {rx_int_enable_q[1], tx_int_enable_q[1]};
        end else if (haddr[7:0] == OFF_FLAG_B) begin
            rd_d[1:0] = {rx_int_flag[1], tx_int_flag[1]};
        end else if (haddr[7:0] == OFF_PRIO_B) begin
            rd_d[1:0] = {rx_int_priority_q[1], tx_int_priority_q[1]};
        end else if (haddr[7:0] == OFF_IRQ_STAT) begin
            rd_d[3:0] = irq_stat_q;
        end else if (haddr[7:0] == OFF_IRQ_MASK) begin
            rd_d[3:0] = irq_mask_q;
        end else if (haddr[7:0] == OFF_CORE_STAT) begin
            rd_d[20:0] = {kind_q, high_act_q, low_act_q, int_req_q, int_vector_q};
        end
    end

    // Read data latched at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            hrdata_q <= rd_d;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_high_raise: assert property (
        (variant_q && priority_mode_select_q && global_int_enable_q && hi_pend)
        |=> (int_req_q && int_vector_q == VEC_HIGH))
        else $error("high request not raised");
    chk_single_gate: assert property (
        (!variant_q && (global_int_disable_q || !peripheral_int_enable_q)) |=> !int_req_q)
        else $error("single-level request while gated");
    chk_take_disable: assert property (
        (int_take && int_req_q && kind_q == KIND_SINGLE) |=> global_int_disable_q)
        else $error("global disable not set on take");
    chk_return_enable: assert property (
        (int_return && !(int_take && int_req_q) && !variant_q) |=> !global_int_disable_q)
        else $error("global disable not cleared on return");
    chk_flag_sticky: assert property (
        rise[0] |=> irq_stat_q[0] [*2])
        else $error("flag event not held");
    chk_low_vector: assert property (
        (variant_q && priority_mode_select_q && global_int_enable_q && peripheral_int_enable_q
         && lo_pend && !hi_pend) |=> (int_req_q && int_vector_q == VEC_LOW))
        else $error("low vector wrong");
    chk_context_save: assert property (
        (int_take && int_req_q && variant_q) |=> (saved_working_q == $past(working_register)
         && saved_bank_q == $past(bank_select_register)))
        else $error("context not saved");
    chk_compat_gate: assert property (
        (variant_q && !priority_mode_select_q && !(global_int_enable_q && peripheral_int_enable_q))
        |=> !int_req_q)
        else $error("compat request while gated");
    chk_high_blocks: assert property (
        (variant_q && priority_mode_select_q && !global_int_enable_q) |=> !int_req_q)
        else $error("request with high enable clear");
    chk_single_vector: assert property (
        (!variant_q && int_req_q) |-> int_vector_q == VEC_PERIPH)
        else $error("single-level vector wrong");
    chk_preempt_low: assert property (
        (low_act_q && variant_q && priority_mode_select_q && global_int_enable_q && hi_pend)
        |=> (int_req_q && kind_q == KIND_HIGH))
        else $error("high did not preempt");

    cov_single_take: cover property (int_take && int_req_q && kind_q == KIND_SINGLE);
    cov_low_take: cover property (int_take && int_req_q && kind_q == KIND_LOW);
    cov_nested: cover property (low_act_q && high_act_q);
    cov_irq: cover property (irq_q);

endmodule
`default_nettype wire

// >>> verification/serial_port_interrupt_control_tb.sv
// Self-checking testbench for the serial port interrupt control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module serial_port_interrupt_control_tb;
    import spic_pkg::*;
    // ********************
    // Signals and instances
    // ********************
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h00000000;
    logic hreadyout, hresp, int_req, int_take, int_return, irq;
    logic [31:0] hrdata;
    logic [1:0] tx_int_flag = 2'h0;
    logic [1:0] rx_int_flag = 2'h0;
    logic [15:0] int_vector, last_vector;
    logic [7:0] working_register = 8'h00;
    logic [7:0] alu_status_register = 8'h00;
    logic [7:0] bank_select_register = 8'h00;
    logic [7:0] saved_working, saved_status, saved_bank, n_taken;
    logic take_en = 1'b1;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    spic_top spic_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .tx_int_flag(tx_int_flag), .rx_int_flag(rx_int_flag),
        .int_req(int_req), .int_vector(int_vector), .int_take(int_take), .int_return(int_return),
        .working_register(working_register), .alu_status_register(alu_status_register),
        .bank_select_register(bank_select_register), .saved_working(saved_working),
        .saved_status(saved_status), .saved_bank(saved_bank), .irq(irq));
    spic_core_model spic_core_model_i (.hclk(hclk), .hresetn(hresetn), .int_req(int_req),
        .int_vector(int_vector), .take_en(take_en), .int_take(int_take), .int_return(int_return),
        .last_vector(last_vector), .n_taken(n_taken));
    // Clock and hang guard
    always #12.5 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // ********************
    // Bus and check tasks
    // ********************
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        ahb(1'b1, a, d, unused);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] got;
        ahb(1'b0, a, 32'h00000000, got);
        `CHK(nm, exp, got)
    endtask
    task automatic flags(input logic [1:0] tx, input logic [1:0] rx);
        @(posedge hclk);
        tx_int_flag <= tx;
        rx_int_flag <= rx;
    endtask
    task automatic quiet(input string nm);
        repeat (4) @(posedge hclk);
        `CHK(nm, 1'b0, int_req)
    endtask
    task automatic expect_take(input logic [15:0] v, input string nm);
        logic [7:0] n0;
        n0 = n_taken;
        repeat (60) begin
            if (n_taken == n0) @(posedge hclk);
        end
        // Let the block act on the take before anything is compared
        @(posedge hclk);
        `CHK("taken", n0 + 8'h01, n_taken)
        `CHK(nm, v, last_vector)
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge hclk);
        `CHK("reset vector", VEC_PERIPH, int_vector)
        hresetn <= 1'b1;
        rdc(OFF_CTRL, {27'h0000000, CTRL_RESET}, "ctrl reset");
        rdc(OFF_PRIO_A, 32'h00000003, "prio reset");
        rdc(8'h30, 32'h00000000, "unmapped");
        rdc(OFF_CORE_STAT, 32'h00000020, "core status reset");
        `CHK("okay response", 1'b0, hresp)
        flags(2'h1, 2'h0);
        rdc(OFF_FLAG_A, 32'h00000001, "flag live");
        quiet("disabled at reset");
        flags(2'h0, 2'h0);
        rdc(OFF_FLAG_A, 32'h00000000, "flag cleared by hw");
        // Single-level variant
        wr(OFF_EN_A, 32'h00000003);
        wr(OFF_CTRL, 32'h00000000);
        flags(2'h1, 2'h0);
        quiet("periph enable off");
        wr(OFF_CTRL, 32'h00000008);
        expect_take(VEC_PERIPH, "single vector");
        rdc(OFF_CTRL, 32'h0000000c, "disable on take");
        flags(2'h0, 2'h0);
        repeat (40) @(posedge hclk);
        rdc(OFF_CTRL, 32'h00000008, "disable after return");
        wr(OFF_CTRL, 32'h0000000c);
        wr(OFF_EN_A, 32'h00000002);
        wr(OFF_CTRL, 32'h00000008);
        flags(2'h1, 2'h0);
        quiet("tx disabled alone");
        flags(2'h1, 2'h1);
        expect_take(VEC_PERIPH, "rx enabled alone");
        flags(2'h0, 2'h0);
        repeat (40) @(posedge hclk);
        wr(OFF_EN_B, 32'h00000001);
        flags(2'h2, 2'h0);
        expect_take(VEC_PERIPH, "second port");
        rdc(OFF_FLAG_B, 32'h00000001, "second flags");
        flags(2'h0, 2'h0);
        repeat (40) @(posedge hclk);
        // Priority variant
        working_register <= 8'ha5;
        alu_status_register <= 8'h3c;
        bank_select_register <= 8'h0f;
        wr(OFF_PRIO_A, 32'h00000000);
        wr(OFF_CTRL, 32'h00000009);
        flags(2'h0, 2'h1);
        quiet("global enable off");
        wr(OFF_CTRL, 32'h00000019);
        expect_take(VEC_HIGH, "unprio vector");
        `CHK("saved working", 8'ha5, saved_working)
        `CHK("saved status", 8'h3c, saved_status)
        `CHK("saved bank", 8'h0f, saved_bank)
        flags(2'h0, 2'h0);
        repeat (40) @(posedge hclk);
        wr(OFF_CTRL, 32'h0000001b);
        flags(2'h0, 2'h1);
        expect_take(VEC_LOW, "low vector");
        flags(2'h0, 2'h0);
        repeat (40) @(posedge hclk);
        wr(OFF_CTRL, 32'h0000000b);
        flags(2'h0, 2'h1);
        quiet("high enable off");
        flags(2'h0, 2'h0);
        wr(OFF_EN_A, 32'h00000003);
        wr(OFF_PRIO_A, 32'h00000002);
        wr(OFF_CTRL, 32'h0000001b);
        take_en <= 1'b0;
        flags(2'h1, 2'h1);
        repeat (4) @(posedge hclk);
        take_en <= 1'b1;
        expect_take(VEC_HIGH, "high first");
        flags(2'h1, 2'h0);
        expect_take(VEC_LOW, "low after");
        flags(2'h0, 2'h0);
        repeat (40) @(posedge hclk);
        // Event interrupt
        wr(OFF_CTRL, 32'h00000004);
        wr(OFF_IRQ_STAT, 32'h0000000f);
        wr(OFF_IRQ_MASK, 32'h00000001);
        flags(2'h1, 2'h0);
        repeat (3) @(posedge hclk);
        `CHK("irq set", 1'b1, irq)
        rdc(OFF_IRQ_STAT, 32'h00000001, "status set");
        wr(OFF_IRQ_STAT, 32'h00000001);
        repeat (3) @(posedge hclk);
        `CHK("irq cleared", 1'b0, irq)
        flags(2'h1, 2'h1);
        repeat (3) @(posedge hclk);
        `CHK("irq masked", 1'b0, irq)
        rdc(OFF_IRQ_STAT, 32'h00000002, "status masked bit");
        finish_test();
    end
endmodule
`default_nettype wire

// >>> verification/spic_core_model.sv
// Core sequencer model that takes, serves and returns interrupts
`timescale 1ns/1ps
`default_nettype none
module spic_core_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Request from the block
    input wire logic int_req,
    input wire logic [15:0] int_vector,
    // Bench control
    input wire logic take_en,
    // Core actions
    output logic int_take,
    output logic int_return,
    output logic [15:0] last_vector,
    output logic [7:0] n_taken
);
    localparam logic [7:0] SERVE = 8'h1e;
    logic busy_q;
    logic [7:0] cnt_q;
    // Take one request, serve it, return, then hold off a few cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_take <= 1'b0;
            int_return <= 1'b0;
            last_vector <= 16'h0000;
            n_taken <= 8'h00;
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
        end else begin
            int_take <= 1'b0;
            int_return <= 1'b0;
            if (busy_q) begin
                if (cnt_q == 8'h00) begin
                    int_return <= 1'b1; // Return ends the service
                    busy_q <= 1'b0;
                    cnt_q <= 8'h03;
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                end
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end else if (take_en && int_req) begin
                int_take <= 1'b1; // One pulse while the request stands
                last_vector <= int_vector;
                n_taken <= n_taken + 8'h01;
                busy_q <= 1'b1;
                cnt_q <= SERVE;
            end
        end
    end
endmodule
`default_nettype wire
